// File: rtl/aos_divider.sv
// Unsigned restoring divider, one quotient bit per cycle
module aos_divider #(
    parameter int NUM_W = 34,
    parameter int DEN_W = 17
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             start,
    input  wire logic [NUM_W-1:0] dividend,
    input  wire logic [DEN_W-1:0] divisor,
    output logic                  done,
    output logic      [NUM_W-1:0] quotient
);
    localparam int          CNT_W = $clog2(NUM_W + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(NUM_W);

    logic [NUM_W-1:0] quo_reg, quo_next;
    logic [DEN_W-1:0] rem_reg, rem_next;
    logic [DEN_W-1:0] den_reg, den_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             busy_reg, busy_next;
    logic             done_reg, done_next;
    logic [DEN_W:0]   trial;
    logic             fits;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        quo_next  = quo_reg;
        rem_next  = rem_reg;
        den_next  = den_reg;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        trial     = {rem_reg, quo_reg[NUM_W-1]};
        fits      = trial >= {1'b0, den_reg};
        if (start) begin
            quo_next  = dividend;
            rem_next  = '0;
            den_next  = divisor;
            cnt_next  = CNT_FULL;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            quo_next = {quo_reg[NUM_W-2:0], fits};
            rem_next = fits ? DEN_W'(trial - {1'b0, den_reg}) : trial[DEN_W-1:0];
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == CNT_W'(1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            quo_reg  <= '0;
            rem_reg  <= '0;
            den_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce) begin
            quo_reg  <= quo_next;
            rem_reg  <= rem_next;
            den_reg  <= den_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign done     = done_reg;
    assign quotient = quo_reg;
endmodule

// File: rtl/aos_pkg.sv
// Constants and types for the analog output scaling block
package aos_pkg;

    localparam int              CHANNELS     = 4;
    localparam int              VAL_W        = 16;
    localparam int              DIFF_W       = 17;
    localparam int              PROD_W       = 34;
    localparam int              DIGITS_W     = 3;

    localparam logic [15:0]     IDX_IN_LOW   = 16'h7320;
    localparam logic [15:0]     IDX_OUT_LOW  = 16'h7321;
    localparam logic [15:0]     IDX_IN_HIGH  = 16'h7322;
    localparam logic [15:0]     IDX_OUT_HIGH = 16'h7323;
    localparam logic [15:0]     IDX_DRIVE    = 16'h7330;

    localparam logic [7:0]      SUB_COUNT    = 8'h04;

    localparam logic [15:0]     RST_IN_LOW   = 16'h01f4;
    localparam logic [15:0]     RST_OUT_LOW  = 16'h0000;
    localparam logic [15:0]     RST_IN_HIGH  = 16'h1194;
    localparam logic [15:0]     RST_OUT_HIGH = 16'h05dc;
    localparam logic [15:0]     RST_DRIVE    = 16'h0000;

    localparam logic [2:0]      DIGITS_MAX   = 3'h4;

    localparam logic [2:0]      KIND_NONE     = 3'h0;
    localparam logic [2:0]      KIND_IN_LOW   = 3'h1;
    localparam logic [2:0]      KIND_OUT_LOW  = 3'h2;
    localparam logic [2:0]      KIND_IN_HIGH  = 3'h3;
    localparam logic [2:0]      KIND_OUT_HIGH = 3'h4;
    localparam logic [2:0]      KIND_DRIVE    = 3'h5;

    typedef enum logic [0:0] {
        ST_LOAD = 1'b0,
        ST_WAIT = 1'b1
    } aos_state_type;

endpackage

// File: rtl/aos_scaler.sv
// Four-channel analog output scaling with object dictionary access
// Operation
// R01 - Configurator keeps lower input breakpoint strictly below upper input breakpoint.
// R02 - Input breakpoints share the process-value decimal-digit resolution.
// R03 - Input at or below lower breakpoint gives lower output breakpoint.
// R04 - Input at or above upper breakpoint gives upper output breakpoint.
// R05 - Lower output above upper output is accepted, giving inverse response.
// R06 - Output breakpoints and field value share field-value digit resolution.
// R07 - Output breakpoints accept any value of the output range.
// R08 - Field value per channel is read-only signed 16-bit entry.
// R09 - Default input breakpoints are 500 and 4500 millivolts.
// R10 - Default output breakpoints are 0 and 1500 milliamperes.
// R11 - Sub-index zero reads 4; sub-indices 1 to 4 pick channels.
// R12 - Configurator should match input breakpoints to control source scaling.
// R13 - Process-value decimal digits range 0 to 4 on signed 16-bit data.
// R14 - Between input breakpoints, output interpolates linearly.
module aos_scaler
    import aos_pkg::*;
(
    input  wire logic                                      sys_clk,
    input  wire logic                                      nrst,
    input  wire logic                                      ce,
    input  wire logic                                      objRead,
    input  wire logic                                      objWrite,
    input  wire logic [15:0]                               objIndex,
    input  wire logic [7:0]                                objSubIndex,
    input  wire logic [aos_pkg::VAL_W-1:0]                 objWriteData,
    output logic      [aos_pkg::VAL_W-1:0]                 objReadData,
    output logic                                           objAck,
    output logic                                           objRefused,
    input  wire logic [aos_pkg::CHANNELS-1:0][aos_pkg::VAL_W-1:0]    processValue,
    input  wire logic [aos_pkg::CHANNELS-1:0][aos_pkg::DIGITS_W-1:0] procDigits,
    input  wire logic [aos_pkg::CHANNELS-1:0][aos_pkg::DIGITS_W-1:0] fieldDigits,
    output logic      [aos_pkg::CHANNELS-1:0][aos_pkg::VAL_W-1:0]    driveValue,
    output logic      [aos_pkg::CHANNELS-1:0]                        digitsFault
);
    import aos_pkg::*;

    localparam int CH_W = $clog2(CHANNELS);

    // ------------------------------------------------------------
    // Object index decode
    // ------------------------------------------------------------
    function automatic logic [2:0] objKind(input logic [15:0] idx);
        case (idx)
            IDX_IN_LOW:   objKind = KIND_IN_LOW;
            IDX_OUT_LOW:  objKind = KIND_OUT_LOW;
            IDX_IN_HIGH:  objKind = KIND_IN_HIGH;
            IDX_OUT_HIGH: objKind = KIND_OUT_HIGH;
            IDX_DRIVE:    objKind = KIND_DRIVE;
            default:      objKind = KIND_NONE;
        endcase
    endfunction

    logic [VAL_W-1:0] inLow_reg   [CHANNELS], inLow_next   [CHANNELS];
    logic [VAL_W-1:0] outLow_reg  [CHANNELS], outLow_next  [CHANNELS];
    logic [VAL_W-1:0] inHigh_reg  [CHANNELS], inHigh_next  [CHANNELS];
    logic [VAL_W-1:0] outHigh_reg [CHANNELS], outHigh_next [CHANNELS];
    logic [VAL_W-1:0] readData_reg, readData_next;
    logic             ack_reg, ack_next;
    logic             refused_reg, refused_next;
    logic [2:0]       kind;
    logic             subOk;
    logic [CH_W-1:0]  subCh;

    // ------------------------------------------------------------
    // Object access
    // ------------------------------------------------------------
    always_comb begin
        inLow_next    = inLow_reg;
        outLow_next   = outLow_reg;
        inHigh_next   = inHigh_reg;
        outHigh_next  = outHigh_reg;
        readData_next = readData_reg;
        ack_next      = 1'b0;
        refused_next  = 1'b0;
        kind          = objKind(objIndex);
        subOk         = (objSubIndex != 8'h00) && (objSubIndex <= SUB_COUNT);
        subCh         = CH_W'(objSubIndex - 8'h01);
        if (objWrite) begin
            // Breakpoints writable with any value
            // R07 any output value
            if (subOk && kind != KIND_NONE && kind != KIND_DRIVE) begin
                ack_next = 1'b1;
                case (kind)
                    KIND_IN_LOW:   inLow_next[subCh]   = objWriteData;
                    KIND_OUT_LOW:  outLow_next[subCh]  = objWriteData;
                    KIND_IN_HIGH:  inHigh_next[subCh]  = objWriteData;
                    KIND_OUT_HIGH: outHigh_next[subCh] = objWriteData;
                    default:       ack_next = 1'b0;
                endcase
            end else begin
                // R08 field value read-only
                refused_next = 1'b1;
            end
        end else if (objRead) begin
            if (kind == KIND_NONE) begin
                refused_next = 1'b1;
            end else if (objSubIndex == 8'h00) begin
                // R11 highest sub-index
                readData_next = {8'h00, SUB_COUNT};
                ack_next      = 1'b1;
            end else if (subOk) begin
                ack_next = 1'b1;
                case (kind)
                    KIND_IN_LOW:   readData_next = inLow_reg[subCh];
                    KIND_OUT_LOW:  readData_next = outLow_reg[subCh];
                    KIND_IN_HIGH:  readData_next = inHigh_reg[subCh];
                    KIND_OUT_HIGH: readData_next = outHigh_reg[subCh];
                    default:       readData_next = driveValue[subCh];
                endcase
            end else begin
                refused_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                // R09 input defaults
                inLow_reg[i]   <= RST_IN_LOW;
                inHigh_reg[i]  <= RST_IN_HIGH;
                // R10 output defaults
                outLow_reg[i]  <= RST_OUT_LOW;
                outHigh_reg[i] <= RST_OUT_HIGH;
            end
            readData_reg <= '0;
            ack_reg      <= 1'b0;
            refused_reg  <= 1'b0;
        end else if (ce) begin
            inLow_reg    <= inLow_next;
            outLow_reg   <= outLow_next;
            inHigh_reg   <= inHigh_next;
            outHigh_reg  <= outHigh_next;
            readData_reg <= readData_next;
            ack_reg      <= ack_next;
            refused_reg  <= refused_next;
        end
    end

    assign objReadData = readData_reg;
    assign objAck      = ack_reg;
    assign objRefused  = refused_reg;

    // ------------------------------------------------------------
    // Channel scaling sequencer
    // ------------------------------------------------------------
    aos_state_type                              state_reg, state_next;
    logic [CH_W-1:0]                            chan_reg, chan_next;
    logic [CHANNELS-1:0][VAL_W-1:0]             drive_reg, drive_next;
    logic [CHANNELS-1:0]                        fault_reg, fault_next;
    logic [VAL_W-1:0]                           baseHeld_reg, baseHeld_next;
    logic                                       negHeld_reg, negHeld_next;
    logic signed [DIFF_W-1:0]                   relIn, spanIn, spanOut;
    logic [DIFF_W-1:0]                          magOut;
    logic [PROD_W-1:0]                          product;
    logic [PROD_W-1:0]                          quotient;
    logic [DIFF_W-1:0]                          quoShort;
    logic [DIFF_W-1:0]                          sum;
    logic                                       divStart;
    logic                                       divDone;

    always_comb begin
        state_next    = state_reg;
        chan_next     = chan_reg;
        drive_next    = drive_reg;
        fault_next    = fault_reg;
        baseHeld_next = baseHeld_reg;
        negHeld_next  = negHeld_reg;
        divStart      = 1'b0;
        // R02 same resolution on both sides cancels
        relIn   = $signed({processValue[chan_reg][VAL_W-1], processValue[chan_reg]})
                - $signed({inLow_reg[chan_reg][VAL_W-1], inLow_reg[chan_reg]});
        spanIn  = $signed({inHigh_reg[chan_reg][VAL_W-1], inHigh_reg[chan_reg]})
                - $signed({inLow_reg[chan_reg][VAL_W-1], inLow_reg[chan_reg]});
        // R05 signed span allows inverse slope
        spanOut = $signed({outHigh_reg[chan_reg][VAL_W-1], outHigh_reg[chan_reg]})
                - $signed({outLow_reg[chan_reg][VAL_W-1], outLow_reg[chan_reg]});
        magOut  = spanOut[DIFF_W-1] ? DIFF_W'(-spanOut) : DIFF_W'(spanOut);
        product = PROD_W'(relIn[DIFF_W-2:0]) * PROD_W'(magOut);
        quoShort = quotient[DIFF_W-1:0];
        sum     = {baseHeld_reg[VAL_W-1], baseHeld_reg}
                + (negHeld_reg ? DIFF_W'(-quoShort) : quoShort);
        case (state_reg)
            ST_LOAD: begin
                chan_next = chan_reg + 1'b1;
                // R13 digit settings 0 to 4
                if (procDigits[chan_reg] > DIGITS_MAX || fieldDigits[chan_reg] > DIGITS_MAX) begin
                    fault_next[chan_reg] = 1'b1;
                end else if (!relIn[DIFF_W-1] && relIn != '0 && $signed(relIn) < spanIn) begin
                    // R14 interior interpolation
                    fault_next[chan_reg] = 1'b0;
                    baseHeld_next = outLow_reg[chan_reg];
                    negHeld_next  = spanOut[DIFF_W-1];
                    divStart      = 1'b1;
                    chan_next     = chan_reg;
                    state_next    = ST_WAIT;
                end else if (relIn[DIFF_W-1] || relIn == '0) begin
                    // R03 clamp low; under R01 violation, input above lower breakpoint clamps high
                    fault_next[chan_reg] = 1'b0;
                    drive_next[chan_reg] = outLow_reg[chan_reg];
                end else begin
                    // R04 clamp high
                    fault_next[chan_reg] = 1'b0;
                    drive_next[chan_reg] = outHigh_reg[chan_reg];
                end
            end
            ST_WAIT: begin
                if (divDone) begin
                    // R06 result in output units
                    drive_next[chan_reg] = sum[VAL_W-1:0];
                    chan_next            = chan_reg + 1'b1;
                    state_next           = ST_LOAD;
                end
            end
            default: begin
                state_next = ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= ST_LOAD;
            chan_reg     <= '0;
            drive_reg    <= {CHANNELS{RST_DRIVE}};
            fault_reg    <= '0;
            baseHeld_reg <= '0;
            negHeld_reg  <= 1'b0;
        end else if (ce) begin
            state_reg    <= state_next;
            chan_reg     <= chan_next;
            drive_reg    <= drive_next;
            fault_reg    <= fault_next;
            baseHeld_reg <= baseHeld_next;
            negHeld_reg  <= negHeld_next;
        end
    end

    aos_divider #(
        .NUM_W (PROD_W),
        .DEN_W (DIFF_W)
    ) u_divider (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .ce       (ce),
        .start    (divStart),
        .dividend (product),
        .divisor  (DIFF_W'(spanIn)),
        .done     (divDone),
        .quotient (quotient)
    );

    assign driveValue  = drive_reg;
    assign digitsFault = fault_reg;
endmodule

// File: tb/aos_master.sv
// Network master model issuing object dictionary accesses
module aos_master
    import aos_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      objAck,
    input  wire logic                      objRefused,
    input  wire logic [aos_pkg::VAL_W-1:0] objReadData,
    output logic                           objRead,
    output logic                           objWrite,
    output logic      [15:0]               objIndex,
    output logic      [7:0]                objSubIndex,
    output logic      [aos_pkg::VAL_W-1:0] objWriteData
);
    import aos_pkg::*;

    initial begin
        objRead      = 1'b0;
        objWrite     = 1'b0;
        objIndex     = 16'h0000;
        objSubIndex  = 8'h00;
        objWriteData = 16'h0000;
    end

    // ------------------------------------------------------------
    // Single access
    // ------------------------------------------------------------
    // One enabled cycle per request, answer sampled in the next cycle
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [VAL_W-1:0] data, output logic ok,
                          output logic [VAL_W-1:0] rd);
        @(negedge sys_clk);
        objWrite     = wr;
        objRead      = !wr;
        objIndex     = idx;
        objSubIndex  = sub;
        objWriteData = data;
        @(negedge sys_clk);
        ok           = objAck && !objRefused;
        rd           = objReadData;
        objWrite     = 1'b0;
        objRead      = 1'b0;
        objIndex     = ~idx;
        objSubIndex  = ~sub;
        objWriteData = ~data;
    endtask
endmodule

// File: tb/aos_scaler_properties.sv
// Assertions on the object port and drive outputs of the scaler
module aos_scaler_properties (
    input wire logic                                                 sys_clk,
    input wire logic                                                 nrst,
    input wire logic                                                 ce,
    input wire logic                                                 objRead,
    input wire logic                                                 objWrite,
    input wire logic [15:0]                                          objIndex,
    input wire logic [7:0]                                           objSubIndex,
    input wire logic [aos_pkg::VAL_W-1:0]                            objWriteData,
    input wire logic [aos_pkg::VAL_W-1:0]                            objReadData,
    input wire logic                                                 objAck,
    input wire logic                                                 objRefused,
    input wire logic [aos_pkg::CHANNELS-1:0][aos_pkg::VAL_W-1:0]    processValue,
    input wire logic [aos_pkg::CHANNELS-1:0][aos_pkg::DIGITS_W-1:0] procDigits,
    input wire logic [aos_pkg::CHANNELS-1:0][aos_pkg::DIGITS_W-1:0] fieldDigits,
    input wire logic [aos_pkg::CHANNELS-1:0][aos_pkg::VAL_W-1:0]    driveValue,
    input wire logic [aos_pkg::CHANNELS-1:0]                        digitsFault
);
    import aos_pkg::*;

    logic [VAL_W-1:0] pickDrive;
    logic             anyReq;
    logic             knownIdx;

    always_comb begin
        pickDrive = driveValue[objSubIndex[1:0] - 2'h1];
        anyReq    = ce && (objRead || objWrite);
        knownIdx  = objIndex inside {IDX_IN_LOW, IDX_OUT_LOW, IDX_IN_HIGH, IDX_OUT_HIGH,
                                     IDX_DRIVE};
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    answer_once_a: assert property (anyReq |=> objAck != objRefused)
        else $error("request not answered by exactly one pulse");
    idle_silent_a: assert property (!anyReq |=> !objAck && !objRefused)
        else $error("answer without request");
    ro_write_refused_a: assert property (anyReq && objWrite
        && (objIndex == IDX_DRIVE || objSubIndex == 8'h00) |=> objRefused)
        else $error("write to read-only entry accepted");
    sub_range_a: assert property (anyReq && objSubIndex > SUB_COUNT |=> objRefused)
        else $error("sub-index above count accepted");
    count_read_a: assert property (anyReq && !objWrite && knownIdx && objSubIndex == 8'h00
        |=> objAck && objReadData == 16'h0004)
        else $error("count entry wrong");
    drive_read_a: assert property (anyReq && !objWrite && objIndex == IDX_DRIVE
        && objSubIndex inside {[8'h01:8'h04]} |=> objAck && objReadData == $past(pickDrive))
        else $error("field value read wrong");
    read_hold_a: assert property ($changed(objReadData) |-> objAck)
        else $error("read data changed without answer");
    fault_freeze_a: assert property (digitsFault[1] ##1 digitsFault[1] |-> $stable(driveValue[1]))
        else $error("drive moved while digits faulted");
    fault_raise_a: assert property ((procDigits[1] > DIGITS_MAX) [*4]
        |-> ##[0:160] digitsFault[1])
        else $error("illegal digits not flagged");
endmodule

bind aos_scaler aos_scaler_properties chk (.sys_clk, .nrst, .ce, .objRead, .objWrite, .objIndex,
    .objSubIndex, .objWriteData, .objReadData, .objAck, .objRefused, .processValue, .procDigits,
    .fieldDigits, .driveValue, .digitsFault);

// File: tb/aos_scaler_test.sv
// Self-checking bench for the analog output scaling block
module aos_scaler_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aos_pkg::*;

    logic                                  sys_clk = 1'b0;
    logic                                  nrst    = 1'b0;
    logic                                  ce      = 1'b1;
    logic                                  objRead;
    logic                                  objWrite;
    logic [15:0]                           objIndex;
    logic [7:0]                            objSubIndex;
    logic [VAL_W-1:0]                      objWriteData;
    logic [VAL_W-1:0]                      objReadData;
    logic                                  objAck;
    logic                                  objRefused;
    logic [CHANNELS-1:0][VAL_W-1:0]        processValue = '0;
    logic [CHANNELS-1:0][DIGITS_W-1:0]     procDigits   = '0;
    logic [CHANNELS-1:0][DIGITS_W-1:0]     fieldDigits  = '0;
    logic [CHANNELS-1:0][VAL_W-1:0]        driveValue;
    logic [CHANNELS-1:0]                   digitsFault;
    int                                    seed = 94;
    int                                    mismatches;
    int                                    checksDone;
    int                                    cycles;
    int                                    bp [4][4];

    always #2.5 sys_clk = ~sys_clk;

    aos_scaler DUT (.sys_clk, .nrst, .ce, .objRead, .objWrite, .objIndex, .objSubIndex,
        .objWriteData, .objReadData, .objAck, .objRefused, .processValue, .procDigits,
        .fieldDigits, .driveValue, .digitsFault);
    aos_master master (.sys_clk, .objAck, .objRefused, .objReadData, .objRead, .objWrite,
        .objIndex, .objSubIndex, .objWriteData);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] expectDrive(int v, int il, int ih, int ol, int oh);
        longint q;
        if (v <= il) return 16'(ol);
        if (v >= ih) return 16'(oh);
        q = (longint'(v - il) * (oh - ol)) / (ih - il);
        return 16'(ol + q);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [15:0] idx, input int sub, input int data,
                        input logic expOk, output logic [15:0] rd);
        logic ok;
        master.access(wr, idx, 8'(sub), 16'(data), ok, rd);
        check({15'h0, ok}, {15'h0, expOk});
    endtask

    task automatic stop_test();
        $display("mismatches %0d, checks %0d", mismatches, checksDone);
        if (mismatches == 0 && checksDone > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] rd;
        logic [15:0] held;
        logic [15:0] idxTab [5] = '{IDX_IN_LOW, IDX_OUT_LOW, IDX_IN_HIGH, IDX_OUT_HIGH, IDX_DRIVE};
        int          inVal [4] = '{500, 4500, 2500, 1234};
        int          a;
        int          b;
        int          t;
        for (int ch = 0; ch < 4; ch++) bp[ch] = '{500, 0, 4500, 1500};
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        // Defaults, count entries and refusals
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, idxTab[i], 0, 0, 1'b1, rd);
            check(rd, 16'h0004);
            xfer(1'b1, idxTab[i], 0, 7, 1'b0, rd);
            xfer(1'b0, idxTab[i], 5, 0, 1'b0, rd);
            for (int ch = 1; ch <= 4 && i < 4; ch++) begin
                xfer(1'b0, idxTab[i], ch, 0, 1'b1, rd);
                check(rd, 16'(bp[0][i]));
            end
        end
        xfer(1'b1, IDX_DRIVE, 1, 9, 1'b0, rd);
        xfer(1'b0, 16'h7324, 1, 0, 1'b0, rd);
        for (int it = 0; it < 21; it++) begin
            for (int ch = 0; ch < 4 && it > 0; ch++) begin
                // Input spans kept strictly increasing
                a = $random(seed) % 30000;
                b = $random(seed) % 30000;
                if (a == b) b = a + 1;
                bp[ch] = '{(a < b) ? a : b, 16'sh0, (a < b) ? b : a, 16'sh0};
                bp[ch][1] = $signed(16'($random(seed)));
                bp[ch][3] = $signed(16'($random(seed)));
                if ((bp[ch][1] > bp[ch][3]) != it[0]) begin
                    t = bp[ch][1];
                    bp[ch][1] = bp[ch][3];
                    bp[ch][3] = t;
                end
                for (int i = 0; i < 4; i++) xfer(1'b1, idxTab[i], ch + 1, bp[ch][i], 1'b1, rd);
                case ($random(seed) & 3)
                    0: inVal[ch] = bp[ch][0];
                    1: inVal[ch] = bp[ch][2];
                    2: inVal[ch] = bp[ch][0] - 1;
                    default: inVal[ch] = bp[ch][0]
                        + (($random(seed) & 32'h7fffffff) % (bp[ch][2] - bp[ch][0] + 1));
                endcase
            end
            for (int ch = 0; ch < 4; ch++) begin
                processValue[ch] = 16'(inVal[ch]);
                procDigits[ch] = 3'(($random(seed) & 32'hff) % 5);
                fieldDigits[ch] = 3'(($random(seed) & 32'hff) % 5);
            end
            repeat (320) @(negedge sys_clk);
            for (int ch = 0; ch < 4; ch++) begin
                t = $random(seed) & 3;
                held = expectDrive(inVal[ch], bp[ch][0], bp[ch][2], bp[ch][1], bp[ch][3]);
                check(driveValue[ch], held);
                xfer(1'b0, IDX_DRIVE, ch + 1, 0, 1'b1, rd);
                check(rd, held);
                xfer(1'b0, idxTab[t], ch + 1, 0, 1'b1, rd);
                check(rd, 16'(bp[ch][t]));
            end
        end
        // Illegal digits freeze the channel
        processValue[1] = 16'(bp[1][0]);
        repeat (320) @(negedge sys_clk);
        check(driveValue[1], 16'(bp[1][1]));
        procDigits[1] = 3'h5;
        fieldDigits[2] = 3'h7;
        repeat (200) @(negedge sys_clk);
        processValue[1] = 16'(bp[1][2] + 1);
        repeat (200) @(negedge sys_clk);
        check(driveValue[1], 16'(bp[1][1]));
        check({15'h0, digitsFault[1]}, 16'h0001);
        check({15'h0, digitsFault[2]}, 16'h0001);
        procDigits[1] = 3'h0;
        fieldDigits[2] = 3'h0;
        repeat (320) @(negedge sys_clk);
        check({15'h0, digitsFault[1]}, 16'h0000);
        check(driveValue[1], 16'(bp[1][3]));
        // Low clock enable freezes the scaling
        ce = 1'b0;
        processValue[1] = 16'(bp[1][0]);
        repeat (100) @(negedge sys_clk);
        check(driveValue[1], 16'(bp[1][3]));
        ce = 1'b1;
        repeat (320) @(negedge sys_clk);
        check(driveValue[1], 16'(bp[1][1]));
        stop_test();
    end
endmodule
